// >>> hdl/skip_call_defines.svh
// Constants for the skip and call execution block
`ifndef SKIP_CALL_DEFINES_SVH
`define SKIP_CALL_DEFINES_SVH
`define FILE_ADDR_W 6
`define BIT_SEL_W 3
`define PC_W 10
`define PC_LOW_W 8
`define PAGE_W 2
`define SKIP_CYCLES 2
`define CALL_CYCLES 2
`define PC_STEP 10'h001
`endif

// >>> hdl/skip_call_pkg.sv
// Types for the skip and call execution block
package skip_call_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_TEST_CLEAR = 4'h1,
        OP_TEST_SET = 4'h2,
        OP_CALL_IMM = 4'h3,
        OP_CALL_ACC = 4'h4
    } op_t;

    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_SKIP = 3'b010,
        ST_CALL = 3'b100
    } state_t;

    typedef struct packed {
        op_t op;
        logic [5:0] fileAddr;
        logic [2:0] bitSel;
        logic [7:0] imm;
    } instr_t;

    typedef struct packed {
        logic push;
        logic [9:0] retAddr;
        logic load;
        logic [9:0] target;
    } pc_update_t;
endpackage

// >>> hdl/bit_tester.sv
// Bit selection and skip condition for the bit-test instructions
`timescale 1ns/1ps
`include "skip_call_defines.svh"
module bit_tester (
    input wire logic [7:0] fileData,
    input wire logic [`BIT_SEL_W-1:0] bitSel,
    input wire logic wantSet,
    output logic skipMet
);
    logic selBit;
    assign selBit = fileData[bitSel];
    // Set test skips on one, clear test on zero
    assign skipMet = wantSet ? selBit : ~selBit;
endmodule

// >>> hdl/skip_and_call_execution.sv
// Execution of bit-test-and-skip and call instructions
`timescale 1ns/1ps
`include "skip_call_defines.svh"
// Overview of operation
// [RULE1] Skip-if-clear skips when tested bit is 0
// [RULE2] Skip-if-set skips when tested bit is 1
// [RULE3] Taken skip turns fetched instruction into no-op
// [RULE4] Bit test: 1 cycle, 2 when skipping
// [RULE5] File address 0-63, bit 0-7 decoded
// [RULE6] Calls push program counter plus one
// [RULE7] Immediate call: {page buffer[1:0], operand}
// [RULE8] Accumulator call: {high pointer[1:0], accumulator}
// [RULE9] Calls take two cycles, flags untouched
module skip_and_call_execution (
    input wire logic clk,
    input wire logic srst,
    input wire logic instrValid,
    input wire skip_call_pkg::instr_t instr,
    input wire logic [9:0] pc,
    input wire logic [7:0] fileData,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] program_page_buffer,
    input wire logic [7:0] table_high_pointer,
    input wire logic [7:0] statusIn,
    output logic [5:0] fileAddr,
    output logic [2:0] bitSel,
    output logic busy,
    output logic squashFetched,
    output skip_call_pkg::pc_update_t pcUpdate,
    output logic [7:0] statusOut,
    output logic instrDone
);
    // ==================================================================
    // Decode
    skip_call_pkg::state_t state;
    skip_call_pkg::state_t next_state;
    logic isTest;
    logic isCall;
    logic skipMet;
    logic take;

    assign take = instrValid && state == skip_call_pkg::ST_EXEC;
    assign isTest = instr.op == skip_call_pkg::OP_TEST_CLEAR ||
                    instr.op == skip_call_pkg::OP_TEST_SET;
    assign isCall = instr.op == skip_call_pkg::OP_CALL_IMM ||
                    instr.op == skip_call_pkg::OP_CALL_ACC;
    assign fileAddr = instr.fileAddr; // RULE5
    assign bitSel = instr.bitSel; // RULE5

    bit_tester tester (
        .fileData(fileData),
        .bitSel(instr.bitSel),
        .wantSet(instr.op == skip_call_pkg::OP_TEST_SET),
        .skipMet(skipMet)
    ); // RULE1 RULE2

    // Stall the fetch stage while the second slot is consumed
    assign busy = state != skip_call_pkg::ST_EXEC;

    // ==================================================================
    // Sequencing
    always_comb begin
        next_state = skip_call_pkg::ST_EXEC;
        case (state)
            skip_call_pkg::ST_EXEC: begin
                if (take && isTest && skipMet) begin
                    next_state = skip_call_pkg::ST_SKIP; // RULE4
                end else if (take && isCall) begin
                    next_state = skip_call_pkg::ST_CALL; // RULE9
                end
            end
            default: begin
                next_state = skip_call_pkg::ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= skip_call_pkg::ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================================
    // Squash of the already fetched instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            squashFetched <= 1'b0;
        end else begin
            squashFetched <= take && isTest && skipMet; // RULE3
        end
    end

    // ==================================================================
    // Program counter and stack update
    logic [9:0] target;
    always_comb begin
        if (instr.op == skip_call_pkg::OP_CALL_ACC) begin
            target = {table_high_pointer[1:0], accumulator}; // RULE8
        end else begin
            target = {program_page_buffer[1:0], instr.imm}; // RULE7
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pcUpdate <= '0;
        end else begin
            pcUpdate.push <= take && isCall; // RULE6
            pcUpdate.retAddr <= pc + `PC_STEP; // RULE6
            pcUpdate.load <= take && isCall;
            pcUpdate.target <= target;
        end
    end

    // ==================================================================
    // Completion and flags
    always_ff @(posedge clk) begin
        if (srst) begin
            instrDone <= 1'b0;
            statusOut <= 8'h00;
        end else begin
            // Flags pass through; neither tests nor calls alter them
            statusOut <= statusIn; // RULE9
            instrDone <= (take && isTest && !skipMet) || busy; // RULE4
        end
    end

    // ==================================================================
    // Checks
    sequence skipTaken;
        take && isTest && skipMet;
    endsequence

    sequence callTaken;
        take && isCall;
    endsequence

    // Completion lands in the second slot, never in the first
    sequence lateDone;
        !instrDone ##1 instrDone;
    endsequence

    skip_squash_a: assert property (@(posedge clk) disable iff (srst)
        skipTaken |=> squashFetched && busy ##1 !busy) // RULE3
        else $error("skip did not squash the next slot");

    skip_length_a: assert property (@(posedge clk) disable iff (srst)
        skipTaken |=> busy ##1 !busy) // RULE4
        else $error("skip did not take two cycles");

    noskip_one_a: assert property (@(posedge clk) disable iff (srst)
        take && isTest && !skipMet |=> !busy && !squashFetched) // RULE4
        else $error("unskipped test did not take one cycle");

    clear_test_a: assert property (@(posedge clk) disable iff (srst)
        take && instr.op == skip_call_pkg::OP_TEST_CLEAR &&
        !fileData[instr.bitSel] |=> squashFetched) // RULE1
        else $error("clear test missed a zero bit");

    set_test_a: assert property (@(posedge clk) disable iff (srst)
        take && instr.op == skip_call_pkg::OP_TEST_SET &&
        fileData[instr.bitSel] |=> squashFetched) // RULE2
        else $error("set test missed a one bit");

    addr_decode_a: assert property (@(posedge clk) disable iff (srst)
        fileAddr == instr.fileAddr && bitSel == instr.bitSel &&
        (!isTest || skipMet == (fileData[bitSel] ==
        (instr.op == skip_call_pkg::OP_TEST_SET)))) // RULE5
        else $error("operand decode wrong");

    call_push_a: assert property (@(posedge clk) disable iff (srst)
        callTaken |=> pcUpdate.push &&
        pcUpdate.retAddr == $past(pc) + 10'h001) // RULE6
        else $error("return address not pushed");

    imm_target_a: assert property (@(posedge clk) disable iff (srst)
        callTaken and instr.op == skip_call_pkg::OP_CALL_IMM |=>
        pcUpdate.target == {$past(program_page_buffer[1:0]),
        $past(instr.imm)}) // RULE7
        else $error("immediate call target wrong");

    acc_target_a: assert property (@(posedge clk) disable iff (srst)
        callTaken and instr.op == skip_call_pkg::OP_CALL_ACC |=>
        pcUpdate.target == {$past(table_high_pointer[1:0]),
        $past(accumulator)}) // RULE8
        else $error("accumulator call target wrong");

    call_cycles_a: assert property (@(posedge clk) disable iff (srst)
        callTaken |=> busy && statusOut == $past(statusIn) ##1 !busy) // RULE9
        else $error("call not two cycles or flags changed");

    skip_done_a: assert property (@(posedge clk) disable iff (srst)
        skipTaken |=> lateDone) // RULE4
        else $error("skip did not finish in its second cycle");

    noskip_done_a: assert property (@(posedge clk) disable iff (srst)
        take && isTest && !skipMet |=> instrDone) // RULE4
        else $error("unskipped test did not finish at once");

    call_done_a: assert property (@(posedge clk) disable iff (srst)
        callTaken |=> lateDone) // RULE9
        else $error("call did not finish in its second cycle");

    squash_pulse_a: assert property (@(posedge clk) disable iff (srst)
        squashFetched |=> !squashFetched) // RULE3
        else $error("squash held longer than one slot");

    push_pulse_a: assert property (@(posedge clk) disable iff (srst)
        pcUpdate.push |=> !pcUpdate.push) // RULE6
        else $error("return address pushed twice");

    busy_refuse_a: assert property (@(posedge clk) disable iff (srst)
        busy |=> !pcUpdate.push && !pcUpdate.load &&
        !squashFetched) // RULE9
        else $error("instruction accepted in second slot");

    call_load_a: assert property (@(posedge clk) disable iff (srst)
        callTaken |=> pcUpdate.load && !squashFetched) // RULE7 RULE8
        else $error("call did not load the counter");

    // Right after reset the flags copy is not yet meaningful
    status_hold_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> statusOut == $past(statusIn)) // RULE9
        else $error("status flags altered");
endmodule

// >>> verification/tb.sv
// Self-checking bench for the skip and call execution block
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        skip_call_pkg::op_t op;
        logic [5:0] addr;
        logic [2:0] bsel;
        logic [7:0] data;
        logic [7:0] imm;
        logic [9:0] pcv;
        logic skip;
        logic call;
        logic [9:0] tgt;
    } row_t;
    // ==================================================
    // Stimulus and design
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic instrValid = 1'b0;
    skip_call_pkg::instr_t instr = '0;
    logic [9:0] pc = 10'h000;
    logic [7:0] fileData = 8'h00;
    logic [7:0] statusIn = 8'h00;
    logic [7:0] accValue = 8'h34;
    logic [7:0] pageBuf = 8'hfd;
    logic [7:0] highPtr = 8'h02;
    logic [9:0] expRet;
    logic twoSlots;
    logic [5:0] fileAddr;
    logic [2:0] bitSel;
    logic busy, squashFetched, instrDone;
    skip_call_pkg::pc_update_t pcUpdate;
    logic [7:0] statusOut;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    // Page buffer low bits 01, high pointer low bits 10
    row_t rows [7] = '{
        '{skip_call_pkg::OP_TEST_CLEAR, 6'h3f, 3'h2, 8'h5a, 8'h00, 10'h010,
          1'b1, 1'b0, 10'h000},
        '{skip_call_pkg::OP_TEST_CLEAR, 6'h00, 3'h7, 8'h80, 8'h00, 10'h011,
          1'b0, 1'b0, 10'h000},
        '{skip_call_pkg::OP_TEST_SET, 6'h15, 3'h3, 8'h5a, 8'h00, 10'h012,
          1'b1, 1'b0, 10'h000},
        '{skip_call_pkg::OP_TEST_SET, 6'h2a, 3'h0, 8'h5a, 8'h00, 10'h013,
          1'b0, 1'b0, 10'h000},
        '{skip_call_pkg::OP_CALL_IMM, 6'h00, 3'h0, 8'h81, 8'hc3, 10'h0a0,
          1'b0, 1'b1, 10'h1c3},
        '{skip_call_pkg::OP_CALL_ACC, 6'h00, 3'h0, 8'h42, 8'h00, 10'h3ff,
          1'b0, 1'b1, 10'h234},
        '{skip_call_pkg::OP_CALL_IMM, 6'h00, 3'h0, 8'h01, 8'h00, 10'h1ff,
          1'b0, 1'b1, 10'h100}};
    row_t r;
    always #2 clk = ~clk;
    skip_and_call_execution u_dut (.clk(clk), .srst(srst),
        .instrValid(instrValid), .instr(instr), .pc(pc),
        .fileData(fileData), .accumulator(accValue),
        .program_page_buffer(pageBuf), .table_high_pointer(highPtr),
        .statusIn(statusIn), .fileAddr(fileAddr), .bitSel(bitSel),
        .busy(busy), .squashFetched(squashFetched), .pcUpdate(pcUpdate),
        .statusOut(statusOut), .instrDone(instrDone));
    // ==================================================
    // Checking and closing
    task automatic check(input string what, input logic [21:0] seen,
                         input logic [21:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs about 22 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ==================================================
    // Sequence
    initial begin
        repeat (2) @(negedge clk);
        check("reset", 22'({busy, squashFetched, instrDone}), 22'h0);
        check("resetPc", 22'(pcUpdate), 22'h0);
        srst = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            instrValid = 1'b1;
            instr = '{r.op, r.addr, r.bsel, r.imm};
            pc = r.pcv;
            fileData = r.data;
            statusIn = r.data ^ 8'hc3;
            twoSlots = r.skip | r.call;
            // Return address wraps within the 10-bit counter
            expRet = r.pcv + 10'h001;
            #1 check("fileAddr", 22'(fileAddr), 22'(r.addr));
            check("bitSel", 22'(bitSel), 22'(r.bsel));
            @(negedge clk);
            instrValid = 1'b0;
            check("skip", 22'(squashFetched), 22'(r.skip));
            check("busy", 22'(busy), 22'(twoSlots));
            check("done1", 22'(instrDone), 22'(!twoSlots));
            check("status", 22'(statusOut), 22'(r.data ^ 8'hc3));
            check("push", 22'(pcUpdate.push), 22'(r.call));
            check("load", 22'(pcUpdate.load), 22'(r.call));
            if (r.call) begin
                check("retAddr", 22'(pcUpdate.retAddr), 22'(expRet));
                check("tgt", 22'(pcUpdate.target), 22'(r.tgt));
            end
            @(negedge clk);
            check("done2", 22'(instrDone), 22'(twoSlots));
            check("idle", 22'({busy, squashFetched, pcUpdate.push}), 22'h0);
        end
        // A call offered while the previous call is still busy is ignored
        instrValid = 1'b1;
        instr = '{skip_call_pkg::OP_CALL_ACC, 6'h00, 3'h0, 8'h00};
        @(negedge clk);
        instr = '{skip_call_pkg::OP_CALL_IMM, 6'h00, 3'h0, 8'h55};
        check("busy", 22'(busy), 22'(1));
        @(negedge clk);
        check("refused", 22'({pcUpdate.push, pcUpdate.load}), 22'h0);
        // Call right after the refused slot, then reset in its second cycle
        instr = '{skip_call_pkg::OP_CALL_IMM, 6'h00, 3'h0, 8'h66};
        pc = 10'h050;
        pageBuf = 8'h02;
        @(negedge clk);
        check("midPush", 22'(pcUpdate.push), 22'h1);
        check("midRet", 22'(pcUpdate.retAddr), 22'h051);
        check("midTgt", 22'(pcUpdate.target), 22'h266);
        srst = 1'b1;
        instrValid = 1'b0;
        @(negedge clk);
        check("midReset", 22'({busy, squashFetched, instrDone}), 22'h0);
        check("midResetPc", 22'(pcUpdate), 22'h0);
        // First request at the first edge after release
        srst = 1'b0;
        instrValid = 1'b1;
        instr = '{skip_call_pkg::OP_TEST_SET, 6'h01, 3'h0, 8'h00};
        fileData = 8'h01;
        @(negedge clk);
        instrValid = 1'b0;
        check("relSkip", 22'(squashFetched), 22'h1);
        @(negedge clk);
        check("relDone", 22'(instrDone), 22'h1);
        give_verdict();
    end
endmodule
